// file: src/dcth_consts.vh
// Purpose: shared constants of the drive command and trip history block
// Assumes: included by dcth_top.v and by the testbench top
// Notes: offsets are byte addresses on the apb register bus
`ifndef DCTH_CONSTS_VH
`define DCTH_CONSTS_VH
// register offsets
`define DCTH_A_SRC 12'h000
`define DCTH_A_DIR 12'h004
`define DCTH_A_FREQ 12'h008
`define DCTH_A_MS0 12'h00c
`define DCTH_A_MS1 12'h010
`define DCTH_A_MS2 12'h014
`define DCTH_A_START 12'h018
`define DCTH_A_MAX0 12'h01c
`define DCTH_A_MAX1 12'h020
`define DCTH_A_MAX2 12'h024
`define DCTH_A_BRKLIM 12'h028
`define DCTH_A_STAT 12'h02c
`define DCTH_A_DCV 12'h030
`define DCTH_A_BRKLF 12'h034
`define DCTH_A_THERM 12'h038
// history window: paddr[11:8], slot paddr[7:5], word paddr[4:2]
`define DCTH_HIST_PAGE 4'h1
`define DCTH_HIST_SLOTS 3'h6
`define DCTH_HIST_WORDS 3'h6
// field positions
`define DCTH_F_LAMP 0
`define DCTH_F_REJ 1
`define DCTH_F_TRIP 2
`define DCTH_F_FORCE 0
// source, direction and limit codes
`define DCTH_FSRC_OPER 8'h02
`define DCTH_RSRC_TERM 8'h01
`define DCTH_RSRC_OPER 8'h02
`define DCTH_KDIR_FWD 2'h0
`define DCTH_KDIR_REV 2'h1
`define DCTH_LIM_BOTH 2'h0
`define DCTH_LIM_FWD 2'h1
`define DCTH_LIM_REV 2'h2
// trip causes
`define DCTH_CAUSE_OL 8'h05
`define DCTH_CAUSE_BRK 8'h06
// scales, 0.1 units
`define DCTH_THERM_FULL 11'h3e8
`define DCTH_PCT_FULL 26'h00003e8
`define DCTH_DCV_MAX 16'h270f
// reset values
`define DCTH_RST_FSRC 8'h02
`define DCTH_RST_RSRC 8'h02
`define DCTH_RST_START 16'h0005
`define DCTH_RST_MAX 16'h0258
`define DCTH_RST_BRKLIM 10'h064
`endif

// file: src/dcth_top.v
// Purpose: drive command gating, direction limit and trip history
// Assumes: one clock, synchronous reset, apb slave with no wait states
// Notes: monitor and datapath inputs share sys_clk_in; pins are synced
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`include "dcth_consts.vh"

module dcth_top (
    // clock and reset
    input wire sys_clk_in,
    input wire reset_in,
    // apb slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    // command pins, asynchronous
    input wire term_fwd_in,
    input wire term_rev_in,
    input wire keypad_run_in,
    input wire remote_fwd_in,
    input wire remote_rev_in,
    input wire remote_mode_in,
    input wire set_select_in,
    input wire third_motor_set_select_in,
    input wire trip_reset_in,
    // datapath inputs, same clock
    input wire ext_trip_in,
    input wire [7:0] ext_trip_cause_in,
    input wire [15:0] out_freq_in,
    input wire [15:0] out_current_in,
    input wire running_in,
    input wire [15:0] dc_bus_in,
    input wire ground_fault_powerup_in,
    input wire [19:0] run_hours_in,
    input wire [19:0] power_hours_in,
    input wire [9:0] braking_load_in,
    input wire [10:0] thermal_load_in,
    input wire [15:0] ext_freq_cmd_in,
    input wire pid_target_is_freq_in,
    input wire [15:0] pid_feedback_in,
    // drive and display outputs
    output reg run_fwd_out,
    output reg run_rev_out,
    output reg direction_reject_out,
    output reg trip_out,
    output reg [15:0] freq_command_out,
    output reg [15:0] pid_feedback_pct_out,
    output reg [15:0] dc_bus_voltage_view_out,
    output reg [9:0] braking_load_factor_view_out,
    output reg [10:0] thermal_load_view_out,
    output reg program_warning_lamp_out,
    output reg [7:0] trip_history_view_newest_out,
    output reg [7:0] trip_history_view_oldest_out
);

    localparam NREC = 36;

    // zero or start..max is acceptable
    function freq_ok;
        input [15:0] v;
        input [15:0] s;
        input [15:0] m;
        begin
            freq_ok = (v == 16'h0000) || ((v >= s) && (v <= m));
        end
    endfunction

    // two-flop synchronisers for the pins
    reg [8:0] sy1_q;
    reg [8:0] sy2_q;
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            sy1_q <= 9'h000;
            sy2_q <= 9'h000;
        end else begin
            sy1_q <= {trip_reset_in, third_motor_set_select_in,
                      set_select_in, remote_mode_in, remote_rev_in,
                      remote_fwd_in, keypad_run_in, term_rev_in,
                      term_fwd_in};
            sy2_q <= sy1_q;
        end
    end
    wire s_tfwd = sy2_q[0];
    wire s_trev = sy2_q[1];
    wire s_krun = sy2_q[2];
    wire s_rfwd = sy2_q[3];
    wire s_rrev = sy2_q[4];
    wire s_rmode = sy2_q[5];
    wire s_set2 = sy2_q[6];
    wire s_third_motor_set_select = sy2_q[7];
    wire s_treset = sy2_q[8];

    // settings
    reg [7:0] fsrc_q;
    reg [7:0] rsrc_q;
    reg [1:0] kdir_q;
    reg [1:0] lim_q;
    reg [15:0] start_q;
    reg [9:0] brklim_q;
    reg [15:0] ms0_q [0:2];
    reg [15:0] max_q [0:2];
    reg [31:0] hist_q [0:NREC-1];
    reg trip_q;
    reg [7:0] cause_q;
    reg cfg_wr_q;
    reg force_q;
    reg lamp_q;
    reg reject_q;

    // active motor set, third over second
    wire [1:0] aset = s_third_motor_set_select ? 2'h2 : (s_set2 ? 2'h1 : 2'h0);
    wire [15:0] ms_act = ms0_q[aset];
    wire [15:0] max_act = max_q[aset];
    wire oper_src = (fsrc_q == `DCTH_FSRC_OPER);
    // frequency command seen by the datapath
    wire [15:0] freq_cmd = oper_src ? ms_act : ext_freq_cmd_in;

    // apb decode
    wire setup = psel_in && !penable_in;
    wire apb_done = psel_in && penable_in && pready_out;
    wire apb_wr = apb_done && pwrite_in && !pslverr_out;
    wire hist_pg = (paddr_in[11:8] == `DCTH_HIST_PAGE);
    wire [2:0] hslot = paddr_in[7:5];
    wire [2:0] hword = paddr_in[4:2];
    wire hist_ok = hist_pg && (hslot < `DCTH_HIST_SLOTS) &&
                   (hword < `DCTH_HIST_WORDS) && (paddr_in[1:0] == 2'h0);
    wire [5:0] hidx = {hslot, 2'h0} + {1'h0, hslot, 1'h0} + {3'h0, hword};
    wire [15:0] wv = pwdata_in[15:0];
    wire fwr_ok = oper_src && freq_ok(wv, start_q, max_act);

    // read data and error for the setup cycle
    reg [31:0] rd;
    reg err;
    always @* begin
        rd = 32'h00000000;
        err = 1'b0;
        case (paddr_in)
            `DCTH_A_SRC: rd = {16'h0000, rsrc_q, fsrc_q};
            `DCTH_A_DIR: rd = {22'h000000, lim_q, 6'h00, kdir_q};
            `DCTH_A_FREQ: begin
                rd = {16'h0000, freq_cmd};
                err = pwrite_in && !fwr_ok;
            end
            `DCTH_A_MS0: rd = {16'h0000, ms0_q[0]};
            `DCTH_A_MS1: rd = {16'h0000, ms0_q[1]};
            `DCTH_A_MS2: rd = {16'h0000, ms0_q[2]};
            `DCTH_A_START: rd = {16'h0000, start_q};
            `DCTH_A_MAX0: rd = {16'h0000, max_q[0]};
            `DCTH_A_MAX1: rd = {16'h0000, max_q[1]};
            `DCTH_A_MAX2: rd = {16'h0000, max_q[2]};
            `DCTH_A_BRKLIM: rd = {22'h000000, brklim_q};
            `DCTH_A_STAT: rd = {16'h0000, cause_q, 5'h00, trip_q,
                                reject_q, lamp_q};
            `DCTH_A_DCV: rd = {16'h0000, dc_bus_voltage_view_out};
            `DCTH_A_BRKLF: rd = {22'h000000, braking_load_factor_view_out};
            `DCTH_A_THERM: rd = {21'h000000, thermal_load_view_out};
            default: begin
                if (hist_ok) begin
                    rd = hist_q[hidx];
                end else begin
                    err = 1'b1;
                end
            end
        endcase
    end

    // apb answer one cycle after setup
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end else begin
            pready_out <= setup;
            if (setup) begin
                pslverr_out <= err;
                prdata_out <= pwrite_in ? 32'h00000000 : rd;
            end else if (apb_done) begin
                pslverr_out <= 1'b0;
            end
        end
    end

    // setting writes
    integer i, h;
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            fsrc_q <= `DCTH_RST_FSRC;
            rsrc_q <= `DCTH_RST_RSRC;
            kdir_q <= `DCTH_KDIR_FWD;
            lim_q <= `DCTH_LIM_BOTH;
            start_q <= `DCTH_RST_START;
            brklim_q <= `DCTH_RST_BRKLIM;
            for (i = 0; i < 3; i = i + 1) begin
                ms0_q[i] <= 16'h0000;
                max_q[i] <= `DCTH_RST_MAX;
            end
        end else if (apb_wr) begin
            case (paddr_in)
                `DCTH_A_SRC: begin
                    fsrc_q <= pwdata_in[7:0];
                    rsrc_q <= pwdata_in[15:8];
                end
                `DCTH_A_DIR: begin
                    kdir_q <= pwdata_in[1:0];
                    lim_q <= pwdata_in[9:8];
                end
                `DCTH_A_FREQ: ms0_q[aset] <= wv;
                `DCTH_A_MS0: ms0_q[0] <= wv;
                `DCTH_A_MS1: ms0_q[1] <= wv;
                `DCTH_A_MS2: ms0_q[2] <= wv;
                `DCTH_A_START: start_q <= wv;
                `DCTH_A_MAX0: max_q[0] <= wv;
                `DCTH_A_MAX1: max_q[1] <= wv;
                `DCTH_A_MAX2: max_q[2] <= wv;
                `DCTH_A_BRKLIM: brklim_q <= pwdata_in[9:0];
                default: ;
            endcase
        end
    end

    // conflict: start above max, or slot outside its range
    wire conf_now = (start_q > max_act) ||
                    !freq_ok(ms_act, start_q, max_act);
    wire stat_wr = apb_wr && (paddr_in == `DCTH_A_STAT);
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            cfg_wr_q <= 1'b0;
            force_q <= 1'b0;
            lamp_q <= 1'b0;
        end else begin
            cfg_wr_q <= apb_wr && (paddr_in != `DCTH_A_STAT);
            force_q <= stat_wr && pwdata_in[`DCTH_F_FORCE];
            if (cfg_wr_q && conf_now) begin
                lamp_q <= 1'b1;
            end else if (!conf_now || force_q) begin
                lamp_q <= 1'b0;
            end
        end
    end

    // trip detection, external first, then thermal, then braking
    wire therm_over = thermal_load_in > `DCTH_THERM_FULL;
    wire brk_over = braking_load_in > brklim_q;
    wire new_trip = !trip_q && (ext_trip_in || therm_over || brk_over);
    wire [7:0] new_cause = ext_trip_in ? ext_trip_cause_in :
                           (therm_over ? `DCTH_CAUSE_OL :
                            `DCTH_CAUSE_BRK);
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            trip_q <= 1'b0;
            cause_q <= 8'h00;
        end else if (new_trip) begin
            trip_q <= 1'b1;
            cause_q <= new_cause;
        end else if (s_treset) begin
            trip_q <= 1'b0;
        end
    end

    // history shift, slot 0 newest
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            for (h = 0; h < NREC; h = h + 1) begin
                hist_q[h] <= 32'h00000000;
            end
        end else if (new_trip) begin
            for (h = NREC - 1; h >= 6; h = h - 1) begin
                hist_q[h] <= hist_q[h-6];
            end
            hist_q[0] <= {24'h000000, new_cause};
            hist_q[1] <= {16'h0000, out_freq_in};
            hist_q[2] <= {16'h0000, running_in ? out_current_in : 16'h0000};
            hist_q[3] <= {16'h0000, ground_fault_powerup_in ? 16'h0000 : dc_bus_in};
            hist_q[4] <= {12'h000, run_hours_in};
            hist_q[5] <= {12'h000, power_hours_in};
        end
    end

    // requested direction per run source
    reg req_fwd;
    reg req_rev;
    always @* begin
        req_fwd = 1'b0;
        req_rev = 1'b0;
        case (rsrc_q)
            `DCTH_RSRC_TERM: begin
                // both together means stop
                req_fwd = s_tfwd && !s_trev;
                req_rev = s_trev && !s_tfwd;
            end
            `DCTH_RSRC_OPER: begin
                if (s_rmode) begin
                    req_fwd = s_rfwd && !s_rrev;
                    req_rev = s_rrev && !s_rfwd;
                end else begin
                    req_fwd = s_krun && (kdir_q == `DCTH_KDIR_FWD);
                    req_rev = s_krun && (kdir_q == `DCTH_KDIR_REV);
                end
            end
            default: begin
                req_fwd = 1'b0;
                req_rev = 1'b0;
            end
        endcase
    end

    // direction limit, any source
    wire fwd_ok = (lim_q == `DCTH_LIM_BOTH) || (lim_q == `DCTH_LIM_FWD);
    wire rev_ok = (lim_q == `DCTH_LIM_BOTH) || (lim_q == `DCTH_LIM_REV);
    wire rej_now = (req_fwd && !fwd_ok) || (req_rev && !rev_ok);

    // pid feedback in 0.1 percent of the active maximum
    wire [25:0] pid_num = pid_feedback_in * `DCTH_PCT_FULL;
    wire [25:0] pid_div = (max_act == 16'h0000) ? 26'h0000000 :
                          pid_num / {10'h000, max_act};
    wire [15:0] pid_pct = (pid_div[25:16] != 10'h000) ? 16'hffff :
                          pid_div[15:0];

    // registered outputs
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            reject_q <= 1'b0;
            run_fwd_out <= 1'b0;
            run_rev_out <= 1'b0;
            direction_reject_out <= 1'b0;
            trip_out <= 1'b0;
            freq_command_out <= 16'h0000;
            pid_feedback_pct_out <= 16'h0000;
            dc_bus_voltage_view_out <= 16'h0000;
            braking_load_factor_view_out <= 10'h000;
            thermal_load_view_out <= 11'h000;
            program_warning_lamp_out <= 1'b0;
            trip_history_view_newest_out <= 8'h00;
            trip_history_view_oldest_out <= 8'h00;
        end else begin
            reject_q <= rej_now;
            run_fwd_out <= req_fwd && fwd_ok && !trip_q;
            run_rev_out <= req_rev && rev_ok && !trip_q;
            direction_reject_out <= rej_now;
            trip_out <= trip_q;
            freq_command_out <= freq_cmd;
            pid_feedback_pct_out <= pid_target_is_freq_in ?
                                    pid_pct : pid_feedback_in;
            dc_bus_voltage_view_out <= (dc_bus_in > `DCTH_DCV_MAX) ?
                                       `DCTH_DCV_MAX : dc_bus_in;
            braking_load_factor_view_out <= braking_load_in;
            thermal_load_view_out <= thermal_load_in;
            program_warning_lamp_out <= lamp_q;
            trip_history_view_newest_out <= hist_q[0][7:0];
            trip_history_view_oldest_out <= hist_q[30][7:0];
        end
    end

endmodule // dcth_top

// file: testbench/dcth_top_monitor.sv
// Purpose: port checker for the drive command and trip history block
// Assumes: bound to dcth_top, single clock, synchronous reset
// Notes: view latencies and apb answer timing as handed over
`timescale 1ns/1ps

module dcth_top_monitor (
    // clock and reset
    input wire sys_clk_in,
    input wire reset_in,
    // apb
    input wire psel_in,
    input wire penable_in,
    input wire [11:0] paddr_in,
    input wire [31:0] prdata_out,
    input wire pready_out,
    input wire pslverr_out,
    // datapath inputs
    input wire ext_trip_in,
    input wire [15:0] dc_bus_in,
    input wire [9:0] braking_load_in,
    input wire [10:0] thermal_load_in,
    // drive and display outputs
    input wire run_fwd_out,
    input wire run_rev_out,
    input wire direction_reject_out,
    input wire trip_out,
    input wire [15:0] dc_bus_voltage_view_out,
    input wire [9:0] braking_load_factor_view_out,
    input wire [10:0] thermal_load_view_out,
    input wire [7:0] trip_history_view_newest_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    // apb setup steps
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_bad_setup;
        psel_in && !penable_in && paddr_in[11:8] == 4'hf;
    endsequence
    // thermal overload seen while not yet tripped
    sequence s_therm_take;
        (thermal_load_in > 11'd1000 && !ext_trip_in) ##1 !trip_out;
    endsequence
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");
    a_ready_after_setup: assert property (s_setup |=> pready_out)
        else $error("no answer in the cycle after setup");
    a_unmapped_err: assert property (s_bad_setup |=> pslverr_out && prdata_out == 32'h0)
        else $error("unmapped access not refused");
    a_dcv_clamp: assert property (!$past(reset_in) |->
        dc_bus_voltage_view_out == ($past(dc_bus_in) > 16'h270f ? 16'h270f : $past(dc_bus_in)))
        else $error("bus voltage view wrong");
    a_brk_view_copy: assert property (!$past(reset_in) |->
        braking_load_factor_view_out == $past(braking_load_in))
        else $error("braking load view wrong");
    a_therm_view_copy: assert property (!$past(reset_in) |->
        thermal_load_view_out == $past(thermal_load_in))
        else $error("thermal load view wrong");
    a_no_dual_run: assert property (!(run_fwd_out && run_rev_out))
        else $error("both directions driven");
    a_reject_stops: assert property (direction_reject_out |-> !run_fwd_out && !run_rev_out)
        else $error("rejected direction still driven");
    a_trip_stops_run: assert property (trip_out |-> !run_fwd_out && !run_rev_out)
        else $error("run while tripped");
    a_thermal_trip: assert property (s_therm_take |=> trip_out &&
        trip_history_view_newest_out == 8'h05)
        else $error("thermal overload trip missing");
endmodule // dcth_top_monitor

bind dcth_top dcth_top_monitor u_mon (.sys_clk_in, .reset_in, .psel_in, .penable_in, .paddr_in,
    .prdata_out, .pready_out, .pslverr_out, .ext_trip_in, .dc_bus_in, .braking_load_in, .thermal_load_in,
    .run_fwd_out, .run_rev_out, .direction_reject_out, .trip_out, .dc_bus_voltage_view_out,
    .braking_load_factor_view_out, .thermal_load_view_out, .trip_history_view_newest_out);

// file: testbench/dcth_plant.sv
// Purpose: power stage model fed by the drive commands
// Assumes: same clock as the block
// Notes: current never drops to zero, so stopped records must clear it
`timescale 1ns/1ps

module dcth_plant (
    // clock and reset
    input wire sys_clk_in,
    input wire reset_in,
    // drive commands
    input wire run_fwd_in,
    input wire run_rev_in,
    input wire [15:0] freq_cmd_in,
    // measured values
    output reg running_out,
    output reg [15:0] out_freq_out,
    output wire [15:0] out_current_out,
    output reg [19:0] run_hours_out,
    output reg [19:0] power_hours_out
);
    // magnetising current flows even at standstill
    assign out_current_out = 16'h0123;
    // stage follows the command one cycle late, power hours keep counting, run hours only while running
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            running_out <= 1'b0;
            out_freq_out <= 16'h0000;
            run_hours_out <= 20'h00000;
            power_hours_out <= 20'h00000;
        end else begin
            running_out <= run_fwd_in | run_rev_in;
            out_freq_out <= (run_fwd_in | run_rev_in) ? freq_cmd_in : 16'h0000;
            power_hours_out <= power_hours_out + 20'h00001;
            if (running_out) begin
                run_hours_out <= run_hours_out + 20'h00001;
            end
        end
    end
endmodule // dcth_plant

// file: testbench/drive_command_trip_history_tb_top.sv
// Purpose: self-checking bench of the drive command and trip history block
// Assumes: apb master holds each request until ready
// Notes: apb results are noted in a queue and compared by a watcher
`timescale 1ns/1ps
`include "dcth_consts.vh"

module drive_command_trip_history_tb_top;
    typedef struct {logic [31:0] d; logic e; logic rd;} dcth_note_t;
    logic sys_clk_in = 0, reset_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
    logic [11:0] paddr_in = 0;
    logic [31:0] pwdata_in = 0;
    logic term_fwd_in = 0, term_rev_in = 0, keypad_run_in = 0, remote_fwd_in = 0, remote_rev_in = 0;
    logic remote_mode_in = 0, set_select_in = 0, third_motor_set_select_in = 0, trip_reset_in = 0;
    logic ext_trip_in = 0, ground_fault_powerup_in = 0, pid_target_is_freq_in = 0;
    logic [7:0] ext_trip_cause_in = 0;
    logic [15:0] dc_bus_in = 0, ext_freq_cmd_in = 0, pid_feedback_in = 0;
    logic [9:0] braking_load_in = 0;
    logic [10:0] thermal_load_in = 0;
    wire [31:0] prdata_out;
    wire pready_out, pslverr_out, running_in, run_fwd_out, run_rev_out, direction_reject_out;
    wire trip_out, program_warning_lamp_out;
    wire [15:0] out_freq_in, out_current_in, freq_command_out, pid_feedback_pct_out, dc_bus_voltage_view_out;
    wire [19:0] run_hours_in, power_hours_in;
    wire [9:0] braking_load_factor_view_out;
    wire [10:0] thermal_load_view_out;
    wire [7:0] trip_history_view_newest_out, trip_history_view_oldest_out;
    int fails = 0, num_checks = 0, i, l, k;
    integer seed = 32'he492de9e;
    logic [31:0] v;
    dcth_note_t n;
    dcth_note_t notes[$];
    logic [11:0] ra[10] = '{12'h000, 12'h004, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c, 12'h020,
        12'h024, 12'h028};
    logic [31:0] rv[10] = '{32'h202, 32'h0, 32'h0, 32'h0, 32'h0, 32'h5, 32'h258, 32'h258, 32'h258, 32'h64};

    dcth_top dut (.*);
    dcth_plant plant (.sys_clk_in, .reset_in, .run_fwd_in(run_fwd_out), .run_rev_in(run_rev_out),
        .freq_cmd_in(freq_command_out), .running_out(running_in), .out_freq_out(out_freq_in),
        .out_current_out(out_current_in), .run_hours_out(run_hours_in), .power_hours_out(power_hours_in));

    // 10 mhz clock
    always #50 sys_clk_in = ~sys_clk_in;

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task cyc(input int c);
        repeat (c) @(posedge sys_clk_in);
    endtask

    // one apb transfer; d is write data or expected read data
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
        @(posedge sys_clk_in);
        psel_in <= 1;
        penable_in <= 0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        notes.push_back('{d, e, !w});
        @(posedge sys_clk_in);
        penable_in <= 1;
        // only the watchdog ends a wait for ready
        do begin
            @(posedge sys_clk_in);
        end while (pready_out !== 1'b1);
        psel_in <= 0;
        penable_in <= 0;
    endtask

    task expect_run(input logic ef, input logic er);
        cyc(5);
        chk("run forward", ef, run_fwd_out);
        chk("run reverse", er, run_rev_out);
        chk("reject", !(ef || er), direction_reject_out);
    endtask

    task clear_trip;
        trip_reset_in <= 1;
        cyc(4);
        trip_reset_in <= 0;
        cyc(4);
    endtask

    task complete_run;
        if (notes.size() != 0) fails++;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // watcher pairs each apb answer with the oldest note
    always @(posedge sys_clk_in) begin
        if (psel_in && penable_in && pready_out === 1'b1 && notes.size() > 0) begin
            n = notes.pop_front();
            chk("apb error", n.e, pslverr_out);
            if (n.rd) chk("apb read", n.d, prdata_out);
        end
    end

    // watchdog
    initial begin
        #600000;
        fails++;
        complete_run;
    end

    // main sequence
    initial begin
        cyc(6);
        reset_in <= 0;
        foreach (ra[j]) apb(0, ra[j], rv[j], 0);
        apb(0, 12'hffc, 0, 1);
        apb(0, 12'h002, 0, 1);
        apb(1, `DCTH_A_DCV, 32'h1234, 0);
        apb(1, `DCTH_A_FREQ, 32'h100, 0);
        apb(0, `DCTH_A_MS0, 32'h100, 0);
        apb(1, `DCTH_A_FREQ, 32'h3, 1);
        apb(1, `DCTH_A_FREQ, 32'h259, 1);
        apb(1, `DCTH_A_FREQ, 32'h0, 0);
        apb(0, `DCTH_A_MS0, 32'h0, 0);
        for (i = 1; i < 3; i++) begin
            set_select_in <= (i == 1);
            third_motor_set_select_in <= (i == 2);
            cyc(4);
            v = 32'h5 + $unsigned($random(seed)) % 32'h254;
            apb(1, `DCTH_A_FREQ, v, 0);
            apb(0, `DCTH_A_MS0 + 12'h4 * i[11:0], v, 0);
            apb(0, `DCTH_A_FREQ, v, 0);
        end
        set_select_in <= 0;
        third_motor_set_select_in <= 0;
        ext_freq_cmd_in <= 16'($random(seed));
        apb(1, `DCTH_A_SRC, 32'h201, 0);
        apb(1, `DCTH_A_FREQ, 32'h0, 1);
        apb(0, `DCTH_A_FREQ, {16'h0, ext_freq_cmd_in}, 0);
        chk("frequency command", {16'h0, ext_freq_cmd_in}, freq_command_out);
        apb(1, `DCTH_A_SRC, 32'h202, 0);
        pid_target_is_freq_in <= 1;
        pid_feedback_in <= 16'h012c;
        cyc(4);
        chk("pid percent", 32'h1f4, pid_feedback_pct_out);
        chk("frequency command", 32'h0, freq_command_out);
        pid_target_is_freq_in <= 0;
        cyc(3);
        chk("pid raw", 32'h12c, pid_feedback_pct_out);
        apb(1, `DCTH_A_START, 32'h300, 0);
        cyc(3);
        chk("lamp", 1, program_warning_lamp_out);
        apb(0, `DCTH_A_STAT, 32'h1, 0);
        apb(1, `DCTH_A_START, 32'h5, 0);
        cyc(3);
        chk("lamp", 0, program_warning_lamp_out);
        apb(1, `DCTH_A_START, 32'h300, 0);
        apb(1, `DCTH_A_STAT, 32'h1, 0);
        cyc(3);
        chk("lamp", 0, program_warning_lamp_out);
        apb(1, `DCTH_A_START, 32'h5, 0);
        // keypad runs over every limit and selector code
        for (l = 0; l < 3; l++) begin
            for (k = 0; k < 2; k++) begin
                apb(1, `DCTH_A_DIR, {22'h0, l[1:0], 6'h0, k[1:0]}, 0);
                keypad_run_in <= 1;
                expect_run(k == 0 && l != 2, k == 1 && l != 1);
                keypad_run_in <= 0;
                cyc(4);
            end
        end
        apb(1, `DCTH_A_DIR, 32'h1, 0);
        remote_mode_in <= 1;
        remote_fwd_in <= 1;
        expect_run(1, 0);
        apb(1, `DCTH_A_DIR, 32'h101, 0);
        remote_fwd_in <= 0;
        remote_rev_in <= 1;
        expect_run(0, 0);
        remote_rev_in <= 0;
        apb(1, `DCTH_A_SRC, 32'h102, 0);
        apb(1, `DCTH_A_DIR, 32'h200, 0);
        term_fwd_in <= 1;
        expect_run(0, 0);
        term_fwd_in <= 0;
        term_rev_in <= 1;
        expect_run(0, 1);
        term_rev_in <= 0;
        // no trip at the limits, trips just above them
        dc_bus_in <= 16'h0fa0;
        thermal_load_in <= 11'd1000;
        braking_load_in <= 10'h064;
        cyc(6);
        chk("trip", 0, trip_out);
        thermal_load_in <= 11'd1001;
        cyc(3);
        chk("newest cause", 32'h05, trip_history_view_newest_out);
        thermal_load_in <= 0;
        clear_trip;
        braking_load_in <= 10'h065;
        cyc(3);
        chk("newest cause", 32'h06, trip_history_view_newest_out);
        braking_load_in <= 0;
        clear_trip;
        apb(0, 12'h108, 32'h0, 0);
        apb(0, 12'h10c, 32'h0fa0, 0);
        for (i = 0; i < 6; i++) begin
            ext_trip_cause_in <= 8'h10 + i[7:0];
            ground_fault_powerup_in <= (i == 5);
            ext_trip_in <= 1;
            cyc(1);
            ext_trip_in <= 0;
            cyc(2);
            clear_trip;
        end
        chk("newest view", 32'h15, trip_history_view_newest_out);
        chk("oldest view", 32'h10, trip_history_view_oldest_out);
        apb(0, 12'h100, 32'h15, 0);
        apb(0, 12'h180, 32'h11, 0);
        apb(0, 12'h1a0, 32'h10, 0);
        apb(0, 12'h10c, 32'h0, 0);
        repeat (20) begin
            dc_bus_in <= 16'($random(seed));
            cyc(1);
        end
        dc_bus_in <= 16'hffff;
        cyc(3);
        chk("bus voltage view", 32'h270f, dc_bus_voltage_view_out);
        complete_run;
    end
endmodule // drive_command_trip_history_tb_top
